// ---- design/dpbsi_ctl.sv ----
// Controller end: makes the link clock, issues bursts, streams and collects words
`timescale 1ns/100ps
`default_nettype none
module dpbsi_ctl #(
  parameter int DW = dpbsi_pkg::DATA_W,
  parameter int AW = dpbsi_pkg::ADDR_W
) (
  input  wire logic                                i_clk,
  input  wire logic                                i_rst_n,
  dpbsi_link_if.ctl                                link,
  input  wire logic                                i_pll_disable_n,
  input  wire logic                                i_rd_req,
  input  wire logic [dpbsi_pkg::ADDR_W-1:0]        i_rd_addr,
  output logic                                     o_rd_ack,
  output logic [dpbsi_pkg::DATA_W-1:0]             o_rd_data,
  output logic                                     o_rd_valid,
  input  wire logic                                i_wr_req,
  input  wire logic [dpbsi_pkg::ADDR_W-1:0]        i_wr_addr,
  input  wire logic [4*dpbsi_pkg::DATA_W-1:0]      i_wr_data,
  input  wire logic [4*dpbsi_pkg::DATA_W/9-1:0]    i_wr_lane_n,
  output logic                                     o_wr_ack
);
  import dpbsi_pkg::*;
  localparam int LN = DW / LANE_W;

  typedef struct packed {
    logic [1:0]          ph;
    logic                k;
    logic                kn;
    logic                rps_n;
    logic                wps_n;
    logic [AW-1:0]       addr;
    logic [DW-1:0]       d;
    logic [LN-1:0]       bw_n;
    logic                pll_n;
    logic                rd_last;
    logic                wr_last;
    logic [4*DW-1:0]     cur_d;
    logic [4*LN-1:0]     cur_bw;
    logic [1:0]          cnt;
    logic [4*DW-1:0]     nxt_d;
    logic [4*LN-1:0]     nxt_bw;
    logic                nxt_v;
    logic                nxt_age;
    logic [DW-1:0]       qs1;
    logic [DW-1:0]       qs2;
    logic                vs1;
    logic                vs2;
    logic [DW-1:0]       rd_data;
    logic                rd_valid;
    logic                rd_ack;
    logic                wr_ack;
  } dpbsi_ctl_st_t;

  dpbsi_ctl_st_t st;
  dpbsi_ctl_st_t next_st;

  always_comb begin
    next_st        = st;
    next_st.ph     = st.ph + 2'h1;
    // Link clock high for two host cycles, low for two
    next_st.k      = (st.ph == PH_K_HI0) || (st.ph == PH_K_HI1);
    next_st.kn     = !next_st.k;
    next_st.pll_n  = i_pll_disable_n;
    next_st.rd_ack = 1'b0;
    next_st.wr_ack = 1'b0;
    next_st.rd_valid = 1'b0;
    // Sampled lines pass two flops before use
    next_st.qs1 = link.q;
    next_st.qs2 = st.qs1;
    next_st.vs1 = link.read_valid_flag;
    next_st.vs2 = st.vs1;
    // Slots sit mid half-period so the device sees stable data on each rise
    if (!st.ph[0]) begin
      next_st.rd_data  = st.qs2;
      next_st.rd_valid = st.vs2;
      if (st.nxt_v && st.nxt_age) begin
        next_st.cur_d = st.nxt_d;
        next_st.cur_bw = st.nxt_bw;
        next_st.d     = st.nxt_d[DW-1:0];
        next_st.bw_n  = st.nxt_bw[LN-1:0];
        next_st.cnt   = 2'h1;
        next_st.nxt_v = 1'b0;
      end else begin
        if (st.nxt_v) begin
          next_st.nxt_age = 1'b1;
        end
        if (st.cnt != CNT_IDLE) begin
          next_st.d    = st.cur_d[int'(st.cnt)*DW +: DW];
          next_st.bw_n = st.cur_bw[int'(st.cnt)*LN +: LN];
          next_st.cnt  = (st.cnt == CNT_LAST) ? CNT_IDLE : st.cnt + 2'h1;
        end else begin
          next_st.bw_n = '1;
        end
      end
    end
    // Selects and address change a quarter period before the positive rise
    if (st.ph == PH_ISSUE) begin
      next_st.rps_n   = 1'b1;
      next_st.wps_n   = 1'b1;
      next_st.rd_last = 1'b0;
      next_st.wr_last = 1'b0;
      if (i_rd_req && !st.rd_last) begin
        next_st.rps_n   = 1'b0;
        next_st.addr    = i_rd_addr[AW-1:0];
        next_st.rd_last = 1'b1;
        next_st.rd_ack  = 1'b1;
      end else if (i_wr_req && !st.wr_last && !st.nxt_v) begin
        next_st.wps_n   = 1'b0;
        next_st.addr    = i_wr_addr[AW-1:0];
        next_st.wr_last = 1'b1;
        next_st.wr_ack  = 1'b1;
        next_st.nxt_d   = i_wr_data;
        next_st.nxt_bw  = i_wr_lane_n;
        next_st.nxt_v   = 1'b1;
        next_st.nxt_age = 1'b0;
      end
    end
  end

  // Single state register
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      st       <= '0;
      st.ph    <= PH_RESET;
      st.kn    <= 1'b1;
      st.rps_n <= 1'b1;
      st.wps_n <= 1'b1;
      st.bw_n  <= '1;
      st.pll_n <= 1'b1;
    end else begin
      st <= next_st;
    end
  end

  assign link.k                 = st.k;
  assign link.kn                = st.kn;
  assign link.read_port_sel_n   = st.rps_n;
  assign link.write_port_sel_n  = st.wps_n;
  assign link.addr              = st.addr;
  assign link.d                 = st.d;
  assign link.byte_lane_write_n = st.bw_n;
  assign link.pll_disable_n     = st.pll_n;
  assign o_rd_ack               = st.rd_ack;
  assign o_rd_data              = st.rd_data;
  assign o_rd_valid             = st.rd_valid;
  assign o_wr_ack               = st.wr_ack;

endmodule // dpbsi_ctl
`default_nettype wire

// ---- design/dpbsi_dev.sv ----
// Burst SRAM device end: DDR write capture, memory array, DDR read burst
`timescale 1ns/100ps
`default_nettype none
module dpbsi_dev #(
  parameter int DW = dpbsi_pkg::DATA_W,
  parameter int AW = dpbsi_pkg::ADDR_W
) (
  dpbsi_link_if.dev  link,
  input  wire logic  i_rst_n
);
  import dpbsi_pkg::*;
  localparam int LN = DW / LANE_W;

  // Positive clock state
  typedef struct packed {
    logic [1:0]    pll_sync;
    logic          rd_prev;
    logic          wr_prev;
    logic          r1_v;
    logic          r2_v;
    logic          r3_v;
    logic [AW-1:0] r1_a;
    logic [AW-1:0] r2_a;
    logic [AW-1:0] r3_a;
    logic          w1_v;
    logic          w2_v;
    logic          w3_v;
    logic [AW-1:0] w1_a;
    logic [AW-1:0] w2_a;
    logic [AW-1:0] w3_a;
    logic [DW-1:0] q_pos;
    logic [DW-1:0] q_neg_next;
    logic          vld_pos;
    logic          vld_neg_next;
    logic          oe;
  } dpbsi_dev_st_t;

  // Negative clock state
  typedef struct packed {
    logic [DW-1:0] d;
    logic [LN-1:0] bw_n;
    logic [DW-1:0] q_neg;
    logic          vld_neg;
  } dpbsi_dev_neg_t;

  dpbsi_dev_st_t  st;
  dpbsi_dev_st_t  next_st;
  dpbsi_dev_neg_t ng;
  dpbsi_dev_neg_t next_ng;

  // Four words per burst address
  logic [DW-1:0] mem [0:(BURST << AW)-1];

  logic          rd_go;
  logic          wr_go;
  logic          lat_one;
  logic          first_v;
  logic          second_v;
  logic [AW-1:0] first_a;
  logic [AW-1:0] second_a;
  logic          wp_en;
  logic          wn_en;
  logic [AW+1:0] wp_idx;
  logic [AW+1:0] wn_idx;

  // Start arbitration: reads win from idle and after a write
  always_comb begin
    rd_go = !link.read_port_sel_n && !st.rd_prev;
    wr_go = !link.write_port_sel_n && !st.wr_prev && !rd_go;
  end

  // Burst word selection for the chosen read latency
  always_comb begin
    lat_one  = !st.pll_sync[1];
    first_v  = lat_one ? st.r1_v : st.r2_v;
    first_a  = lat_one ? st.r1_a : st.r2_a;
    second_v = lat_one ? st.r2_v : st.r3_v;
    second_a = lat_one ? st.r2_a : st.r3_a;
  end

  // Write slots: word 0 and 2 on the positive rise, 1 and 3 from the negative capture
  always_comb begin
    wp_en  = st.w1_v || st.w2_v;
    wp_idx = st.w1_v ? {st.w1_a, 2'h0} : {st.w2_a, 2'h2};
    wn_en  = st.w2_v || st.w3_v;
    wn_idx = st.w2_v ? {st.w2_a, 2'h1} : {st.w3_a, 2'h3};
  end

  // Next positive clock state
  always_comb begin
    next_st          = st;
    next_st.pll_sync = {st.pll_sync[0], link.pll_disable_n};
    next_st.rd_prev  = rd_go;
    next_st.wr_prev  = wr_go;
    // Address taken only for the port that starts
    next_st.r1_v = rd_go;
    if (rd_go) begin
      next_st.r1_a = link.addr;
    end
    next_st.r2_v = st.r1_v;
    next_st.r2_a = st.r1_a;
    next_st.r3_v = st.r2_v;
    next_st.r3_a = st.r2_a;
    next_st.w1_v = wr_go;
    if (wr_go) begin
      next_st.w1_a = link.addr;
    end
    next_st.w2_v = st.w1_v;
    next_st.w2_a = st.w1_a;
    next_st.w3_v = st.w2_v;
    next_st.w3_a = st.w2_a;
    // Lowest word on the positive rise, then alternating edges
    next_st.vld_pos      = first_v || second_v;
    next_st.vld_neg_next = first_v || second_v;
    next_st.oe           = first_v || second_v;
    if (first_v) begin
      next_st.q_pos      = mem[{first_a, 2'h0}];
      next_st.q_neg_next = mem[{first_a, 2'h1}];
    end else if (second_v) begin
      next_st.q_pos      = mem[{second_a, 2'h2}];
      next_st.q_neg_next = mem[{second_a, 2'h3}];
    end
  end

  // Positive clock register
  always_ff @(posedge link.k or negedge i_rst_n) begin
    if (!i_rst_n) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  // Memory array has no reset; writes are lane masked
  always_ff @(posedge link.k) begin
    for (int l = 0; l < LN; l++) begin
      if (wp_en && !link.byte_lane_write_n[l]) begin
        mem[wp_idx][l*LANE_W +: LANE_W] <= link.d[l*LANE_W +: LANE_W];
      end
      if (wn_en && !ng.bw_n[l]) begin
        mem[wn_idx][l*LANE_W +: LANE_W] <= ng.d[l*LANE_W +: LANE_W];
      end
    end
  end

  // Negative clock capture and second-half output word
  always_comb begin
    next_ng         = ng;
    next_ng.d       = link.d;
    next_ng.bw_n    = link.byte_lane_write_n;
    next_ng.q_neg   = st.q_neg_next;
    next_ng.vld_neg = st.vld_neg_next;
  end

  // Half-cycle path from the positive domain; both clocks share one source
  always_ff @(posedge link.kn or negedge i_rst_n) begin
    if (!i_rst_n) begin
      ng <= '0;
    end else begin
      ng <= next_ng;
    end
  end

  // DDR output mux picks the register of the clock that rose last
  assign link.q               = link.k ? st.q_pos : ng.q_neg;
  assign link.read_valid_flag = link.k ? st.vld_pos : ng.vld_neg;
  assign link.q_oe_n          = !st.oe;
  // Echo clocks follow the input clocks, running regardless of traffic
  assign link.echo_clk        = link.k;
  assign link.echo_clk_n      = link.kn;

endmodule // dpbsi_dev
`default_nettype wire

// ---- design/dpbsi_link_if.sv ----
// Link wires between the burst SRAM device and its controller
`timescale 1ns/100ps
`default_nettype none
interface dpbsi_link_if #(
  parameter int DW = dpbsi_pkg::DATA_W,
  parameter int AW = dpbsi_pkg::ADDR_W
);
  localparam int LN = DW / dpbsi_pkg::LANE_W;
  logic          k;
  logic          kn;
  logic          read_port_sel_n;
  logic          write_port_sel_n;
  logic [AW-1:0] addr;
  logic [DW-1:0] d;
  logic [LN-1:0] byte_lane_write_n;
  logic          pll_disable_n;
  logic [DW-1:0] q;
  logic          q_oe_n;
  logic          read_valid_flag;
  logic          echo_clk;
  logic          echo_clk_n;
  modport dev (
    input  k, kn, read_port_sel_n, write_port_sel_n, addr, d, byte_lane_write_n, pll_disable_n,
    output q, q_oe_n, read_valid_flag, echo_clk, echo_clk_n
  );
  modport ctl (
    output k, kn, read_port_sel_n, write_port_sel_n, addr, d, byte_lane_write_n, pll_disable_n,
    input  q, q_oe_n, read_valid_flag, echo_clk, echo_clk_n
  );
endinterface
`default_nettype wire

// ---- design/dpbsi_pkg.sv ----
// Shared constants for the dual-port burst SRAM link and both of its ends
// Overview of operation
// - Device samples write data on both clock rises
// - Low write select on clock rise starts write
// - Low lane select writes its 9-bit lane
// - Shared address captured on positive clock rise
// - Address ignored for an unselected port
// - Read data driven both edges, then tri-stated
// - Low read select starts four-word read burst
// - Finish burst, release outputs after next rise
// - Valid flag marks read data, echo aligned
// - Accesses start only on positive clock rise
// - Free-running echo clocks follow positive clock
// - PLL disabled gives one-cycle read latency
// - PLL enabled gives two-cycle read latency
// - Lowest word first, then alternating edges
// - Second read on consecutive rise is ignored
// - Reads every other rise give continuous data
// - Write words captured from next rise onward
// - Second write on consecutive rise is discarded
// - Both selects from idle alternate, read first
// - Power-up: ports deselected, outputs high impedance
package dpbsi_pkg;
  localparam int DATA_W = 18;          // Word width, 18 or 36
  localparam int ADDR_W = 21;          // Burst address width, 21 or 20
  localparam int LANE_W = 9;           // Bits per byte lane
  localparam int BURST  = 4;           // Words per access
  localparam int LAT_PLL_ON  = 2;      // Read latency with PLL running
  localparam int LAT_PLL_OFF = 1;      // Read latency with PLL off
  localparam real PLL_OFF_MAX_MHZ = 167.0;
  localparam real HOST_CLK_MHZ    = 100.0;
  // Host clock cycles per link clock period
  localparam int K_DIV = 4;
  localparam real LINK_MHZ = HOST_CLK_MHZ / K_DIV;
  // Host divider phases: edge ph 2->3 issues, even phases are data slots
  localparam logic [1:0] PH_RESET = 2'h0;
  localparam logic [1:0] PH_ISSUE = 2'h2;
  localparam logic [1:0] PH_K_HI0 = 2'h3;
  localparam logic [1:0] PH_K_HI1 = 2'h0;
  localparam logic [1:0] CNT_IDLE = 2'h0;
  localparam logic [1:0] CNT_LAST = 2'h3;
endpackage

// ---- sim/dpbsi_checker.sv ----
// Link-side assertions for the burst SRAM link, both ends
`timescale 1ns/100ps
`default_nettype none
module dpbsi_checker #(
  parameter int DW = dpbsi_pkg::DATA_W,
  parameter int AW = dpbsi_pkg::ADDR_W
) (
  input wire logic                             i_rst_n,
  input wire logic                             k,
  input wire logic                             kn,
  input wire logic                             read_port_sel_n,
  input wire logic                             write_port_sel_n,
  input wire logic [AW-1:0]                    addr,
  input wire logic [DW-1:0]                    d,
  input wire logic [DW/dpbsi_pkg::LANE_W-1:0]  byte_lane_write_n,
  input wire logic                             pll_disable_n,
  input wire logic [DW-1:0]                    q,
  input wire logic                             q_oe_n,
  input wire logic                             read_valid_flag,
  input wire logic                             echo_clk,
  input wire logic                             echo_clk_n
);
  import dpbsi_pkg::*;
  logic       rd_prev, wr_prev, rd_go, wr_go, pll_on, pll_off;
  logic [2:0] pll_hist;
  // Starts as the device must take them; read wins a tie
  assign rd_go   = !read_port_sel_n && !rd_prev;
  assign wr_go   = !write_port_sel_n && !wr_prev && !rd_go;
  assign pll_on  = &{pll_hist, pll_disable_n};
  assign pll_off = ~|{pll_hist, pll_disable_n};
  // Start history; mode counts only after three steady rises (device syncs it)
  always_ff @(posedge k or negedge i_rst_n) begin
    if (!i_rst_n) begin
      rd_prev  <= 1'b0;
      wr_prev  <= 1'b0;
      pll_hist <= 3'h5;
    end else begin
      rd_prev  <= rd_go;
      wr_prev  <= wr_go;
      pll_hist <= {pll_hist[1:0], pll_disable_n};
    end
  end
  default clocking cb @(posedge k); endclocking
  default disable iff (!i_rst_n);
  sequence s_rd_on; rd_go && pll_on; endsequence
  sequence s_beats; (!q_oe_n && read_valid_flag) [*2]; endsequence
  property p_rd_lat_on; s_rd_on |-> ##3 s_beats; endproperty
  property p_rd_lat_off; rd_go && pll_off |-> ##2 s_beats; endproperty
  property p_rd_release; s_rd_on ##2 !rd_go |-> ##3 (q_oe_n && !read_valid_flag); endproperty
  property p_rd_stream; s_rd_on ##2 rd_go |-> ##1 (!q_oe_n && read_valid_flag) [*4]; endproperty
  property p_oe_cause;
    $fell(q_oe_n) |-> ($past(rd_go, 3) && $past(pll_on, 3)) || ($past(rd_go, 2) && $past(pll_off, 2));
  endproperty
  property p_vld_oe; read_valid_flag |-> !q_oe_n; endproperty
  property p_no_rd_twice; !read_port_sel_n |-> !rd_prev; endproperty
  property p_no_wr_twice; !write_port_sel_n |-> !wr_prev; endproperty
  property p_lanes; byte_lane_write_n != '1 |-> $past(wr_go) || $past(wr_go, 2) || $past(wr_go, 3); endproperty
  property p_echo; echo_clk_n != echo_clk && $stable(echo_clk); endproperty
  a_rd_lat_on: assert property (p_rd_lat_on) else $error("read burst off time");
  a_rd_lat_off: assert property (p_rd_lat_off) else $error("short latency burst off time");
  a_rd_release: assert property (p_rd_release) else $error("read outputs not released");
  a_rd_stream: assert property (p_rd_stream) else $error("paired reads not continuous");
  a_oe_cause: assert property (p_oe_cause) else $error("outputs driven without a read");
  a_vld_oe: assert property (p_vld_oe) else $error("valid flag outside burst");
  a_no_rd_twice: assert property (p_no_rd_twice) else $error("read requested twice in a row");
  a_no_wr_twice: assert property (p_no_wr_twice) else $error("write requested twice in a row");
  a_lanes: assert property (p_lanes) else $error("lane enable outside write");
  a_echo: assert property (p_echo) else $error("echo clocks not following");
endmodule // dpbsi_checker
`default_nettype wire

// ---- sim/tb_top.sv ----
// Testbench joining controller and device ends of the burst SRAM link
`timescale 1ns/100ps
`default_nettype none
module tb_top;
  import dpbsi_pkg::*;
  localparam int SAW = 8; // Small array keeps the run short
  logic                  clk, rst_n, pll_n, rd_req, wr_req, rd_ack, rd_valid, wr_ack;
  logic [ADDR_W-1:0]     rd_addr, wr_addr;
  logic [4*DATA_W-1:0]   wr_data;
  logic [4*DATA_W/9-1:0] wr_lane_n;
  logic [DATA_W-1:0]     rd_data;
  logic [DATA_W-1:0]     mem [int];
  logic [DATA_W-1:0]     exp_q [$];
  int                    err_count, cmp_count, base;
  time                   t_r, t_w;
  dpbsi_link_if #(.DW(DATA_W), .AW(SAW)) link ();
  dpbsi_dev #(.DW(DATA_W), .AW(SAW)) i_dpbsi_dev (.link(link), .i_rst_n(rst_n));
  dpbsi_ctl #(.DW(DATA_W), .AW(SAW)) i_dpbsi_ctl (.i_clk(clk), .i_rst_n(rst_n), .link(link),
    .i_pll_disable_n(pll_n), .i_rd_req(rd_req), .i_rd_addr(rd_addr), .o_rd_ack(rd_ack),
    .o_rd_data(rd_data), .o_rd_valid(rd_valid), .i_wr_req(wr_req), .i_wr_addr(wr_addr),
    .i_wr_data(wr_data), .i_wr_lane_n(wr_lane_n), .o_wr_ack(wr_ack));
  dpbsi_checker #(.DW(DATA_W), .AW(SAW)) i_dpbsi_checker (.i_rst_n(rst_n), .k(link.k), .kn(link.kn),
    .read_port_sel_n(link.read_port_sel_n), .write_port_sel_n(link.write_port_sel_n),
    .addr(link.addr), .d(link.d), .byte_lane_write_n(link.byte_lane_write_n),
    .pll_disable_n(link.pll_disable_n), .q(link.q), .q_oe_n(link.q_oe_n),
    .read_valid_flag(link.read_valid_flag), .echo_clk(link.echo_clk), .echo_clk_n(link.echo_clk_n));
  task automatic chk(input logic [71:0] got, input logic [71:0] exp);
    cmp_count++;
    if (got !== exp) begin
      err_count++;
      $display("mismatch at %0t: got %0h expected %0h", $time, got, exp);
    end
  endtask
  task automatic end_of_test;
    $display("comparisons %0d mismatches %0d", cmp_count, err_count);
    if (err_count == 0 && cmp_count > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  function automatic logic [71:0] pat(input int a, input int s);
    for (int i = 0; i < 4; i++) pat[i*18+:18] = 18'(a * 64 + s * 16 + i) + 18'h2A5A0;
  endfunction
  // Hold the request until acked, then update the reference array per lane
  task automatic wr(input int a, input logic [71:0] dat, input logic [7:0] ln);
    int n;
    @(posedge clk);
    wr_addr <= ADDR_W'(a);
    wr_data <= dat;
    wr_lane_n <= ln;
    wr_req <= 1'b1;
    for (n = 0; n < 40 && wr_ack !== 1'b1; n++) @(posedge clk);
    wr_req <= 1'b0;
    t_w = $time;
    chk(72'(n < 40), 72'h1);
    for (int i = 0; i < 8; i++) if (!ln[i]) mem[a*4+i/2][(i%2)*9+:9] = dat[i*9+:9];
  endtask
  // Issue one read; its four words are queued for the collector in burst order
  task automatic rd(input int a);
    int n;
    @(posedge clk);
    rd_addr <= ADDR_W'(a);
    rd_req <= 1'b1;
    for (n = 0; n < 40 && rd_ack !== 1'b1; n++) @(posedge clk);
    rd_req <= 1'b0;
    t_r = $time;
    chk(72'(n < 40), 72'h1);
    for (int i = 0; i < 4; i++) exp_q.push_back(mem[a*4+i]);
  endtask
  // Every received word against the oldest expected one
  always @(posedge clk) begin
    if (rd_valid === 1'b1) begin
      chk(72'(exp_q.size() != 0), 72'h1);
      if (exp_q.size() != 0) chk(72'(rd_data), 72'(exp_q.pop_front()));
    end
  end
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  // Watchdog: the whole sequence needs a few microseconds
  initial begin
    #50us;
    err_count++;
    end_of_test();
  end
  initial begin
    {rst_n, rd_req, wr_req, rd_addr, wr_addr, wr_data} = '0;
    pll_n = 1'b1;
    wr_lane_n = '1;
    err_count = 0;
    cmp_count = 0;
    repeat (8) @(posedge clk);
    chk(72'(link.q_oe_n), 72'h1);
    chk(72'(link.read_valid_flag), 72'h0);
    rst_n <= 1'b1;
    // Long-latency pass first, then short-latency pass
    for (int m = 0; m < 2; m++) begin
      pll_n <= (m == 0);
      repeat (40) @(posedge clk);
      base = m * 8;
      for (int a = 0; a < 3; a++) wr(base + a, pat(base + a, 0), 8'h00);
      wr(base, pat(base, 1), 8'b1001_0110);
      repeat (24) @(posedge clk);
      // Both requests at once: read goes first, write on the next start
      fork
        rd(base);
        wr(base + 3, pat(base + 3, 2), 8'h00);
      join
      chk(72'(t_r < t_w), 72'h1);
      rd(base + 1);
      rd(base + 2);
      rd(base + 3);
      for (int n = 0; n < 200 && exp_q.size() != 0; n++) @(posedge clk);
      chk(72'(exp_q.size()), 72'h0);
    end
    end_of_test();
  end
endmodule // tb_top
`default_nettype wire
